/* File: logic/dmtw_mmu.sv */
// Contract
// [R1] Permission field: upper bit 0 no access, 10 read-only, 11 full.
// [R2] Level-one low bits 00 fault, 01 coarse table base in 31:10.
// [R3] Level-one low bits 10 section, 11 fine table pointer.
// [R4] Section translation comes from level-one descriptor alone.
// [R5] Level-one address is table base joined to top four address bits.
// [R6] Software aligns the level-one table on 128 bytes.
// [R7] Coarse table indexed by bits 19:12, fine table by 19:10.
// [R8] Coarse table: 256 word entries, each covering 4K bytes.
// [R9] Fine table: 1024 word entries, each covering 1K bytes.
// [R10] Software repeats a large page descriptor in 16 coarse entries.
// [R11] Large page groups start at coarse index multiple of 16.
// [R12] A large page is cached in one buffer entry.
// [R13] Software aligns coarse tables on 1024 bytes.
// [R14] Software aligns fine tables on 4096 bytes.
// [R15] Level-two 00 fault, 01 large, 10 small, 11 tiny; large base 31:16.
// [R16] Search buffer first; on miss walk tables then update buffer.
// [R17] Replacement entry chosen at random among unlocked entries.
// [R18] First n entries below base pointer never overwritten by walks.
// [R19] Victim pointer names the next entry written, walk or manual.
// [R20] Walk results written automatically; manual writes also accepted.
// [R21] Fully associative tag search; tag holds type, preserved, valid.
// [R22] Entry data holds physical base and permission field.
// [R23] Entries with valid clear never hit.
// [R24] Global flush keeps preserved entries; single flush removes any.
// [R25] Access conflicting with permission field raises permission fault.
// [R26] Physical address is base bits plus 20/16/12/10 offset bits.
// [R27] Requester stalls during a walk until translation or fault.
`timescale 1ns/1ps
module dmtw_mmu
	import dmtw_pkg::*;
(
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Bus strobe
	input wire logic wb_we_i, // Bus write
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte lanes
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Bus acknowledge
	input wire logic req_valid_i, // Translation request held
	input wire logic [23:0] req_vaddr_i, // Virtual address
	input wire logic req_write_i, // Access is a write
	output logic req_stall_o, // Requester must wait
	output logic rsp_valid_o, // Translation done pulse
	output logic [31:0] rsp_paddr_o, // Physical address
	output logic [1:0] rsp_fault_o, // Fault code
	output logic mem_req_o, // Descriptor fetch
	output logic [31:0] mem_addr_o, // Descriptor address
	input wire logic mem_ack_i, // Descriptor ready
	input wire logic [31:0] mem_rdata_i // Descriptor word
);

	// ****************************************
	// Declarations
	// ****************************************
	dmtw_state_t state_r;
	logic [23:0] va_r;
	logic wr_r;
	logic [31:0] ctrl_r, ttb_r, cam_reg_r, ram_reg_r, faddr_r;
	logic [1:0] fcode_r;
	logic [DMTW_IDX_W-1:0] base_r, victim_r, hit_idx, ram_raddr;
	logic [4:0] lfsr_r;
	logic [DMTW_VTAG_W-1:0] cam_tag_r [DMTW_ENTRIES];
	logic [1:0] cam_sz_r [DMTW_ENTRIES];
	logic [DMTW_ENTRIES-1:0] cam_pres_r, cam_valid_r, hit_vec, fl_vec;
	logic hit_any, ctrl_en, walk_en, rsp_valid_r, wb_go, wb_wr;
	logic [DMTW_VTAG_W-1:0] fill_tag_r;
	logic [1:0] fill_sz_r, fill_ap_r, hit_ap;
	logic [DMTW_PTAG_W-1:0] fill_ptag_r;
	logic [DMTW_RAM_W-1:0] ram_q;
	logic fill_we, man_we, tlb_we, cmd_go;
	logic [31:0] rd_mux, mem_addr_r, rsp_paddr_r;
	logic [1:0] rsp_fault_r;
	logic [31:0] walk_desc;
	logic [DMTW_IDX_W-1:0] victim_nxt;

	assign ctrl_en = ctrl_r[CTRL_EN_BIT];
	assign walk_en = ctrl_r[CTRL_WALK_BIT];
	assign walk_desc = mem_rdata_i;
	assign hit_ap = ram_q[RAM_AP_LSB +: 2];

	// ****************************************
	// Tag search
	// ****************************************
	// Masked compare per entry, for lookup and for single flush
	genvar gi;
	generate
		for (gi = 0; gi < DMTW_ENTRIES; gi++) begin : g_cam
			assign hit_vec[gi] = cam_valid_r[gi] && // [R23]
				(((cam_tag_r[gi] ^ va_r[VA_MSB:VA_TAG_LSB]) &
				dmtw_tag_mask(cam_sz_r[gi])) == '0); // [R21]
			assign fl_vec[gi] = cam_valid_r[gi] &&
				(((cam_tag_r[gi] ^ cam_reg_r[DMTW_VTAG_W-1:0]) &
				dmtw_tag_mask(cam_sz_r[gi])) == '0);
		end
	endgenerate

	// Lowest matching entry
	always_comb begin
		hit_idx = '0;
		for (int i = DMTW_ENTRIES - 1; i >= 0; i--) begin
			if (hit_vec[i]) begin
				hit_idx = DMTW_IDX_W'(i);
			end
		end
	end
	assign hit_any = |hit_vec;

	// ****************************************
	// Buffer entry storage
	// ****************************************
	assign fill_we = (state_r == S_FILL); // [R20]
	assign man_we = cmd_go && wb_dat_i[CMD_LOAD_BIT]; // [R20]
	assign tlb_we = fill_we || man_we;
	assign ram_raddr = (state_r == S_SRCH) ? hit_idx : victim_r;

	dmtw_tlb_ram u_ram (
		.clk_i(clk_i),
		.we_i(tlb_we),
		.waddr_i(victim_r), // [R19]
		.wdata_i(fill_we ? {fill_ap_r, fill_ptag_r} : // [R22]
			{ram_reg_r[RAM_AP_LSB +: 2], ram_reg_r[DMTW_PTAG_W-1:0]}),
		.raddr_i(ram_raddr),
		.rdata_o(ram_q)
	);

	// Tag part: write, global flush, single flush
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cam_valid_r <= '0;
			cam_pres_r <= '0;
		end else if (fill_we) begin
			cam_tag_r[victim_r] <= fill_tag_r; // [R12]
			cam_sz_r[victim_r] <= fill_sz_r;
			cam_pres_r[victim_r] <= 1'b0;
			cam_valid_r[victim_r] <= 1'b1; // [R16]
		end else if (man_we) begin
			cam_tag_r[victim_r] <= cam_reg_r[DMTW_VTAG_W-1:0];
			cam_sz_r[victim_r] <= cam_reg_r[CAM_SZ_LSB +: 2];
			cam_pres_r[victim_r] <= cam_reg_r[CAM_PRES_BIT]; // [R21]
			cam_valid_r[victim_r] <= cam_reg_r[CAM_VALID_BIT];
		end else if (cmd_go && wb_dat_i[CMD_GFLUSH_BIT]) begin
			cam_valid_r <= cam_valid_r & cam_pres_r; // [R24]
		end else if (cmd_go && wb_dat_i[CMD_FLENT_BIT]) begin
			cam_valid_r <= cam_valid_r & ~fl_vec; // [R24]
		end
	end

	// ****************************************
	// Replacement
	// ****************************************
	// Free-running random source
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lfsr_r <= LFSR_SEED;
		end else begin
			lfsr_r <= {lfsr_r[3:0], lfsr_r[4] ^ lfsr_r[2]};
		end
	end

	// Next victim drawn at random above the locked region
	assign victim_nxt = (lfsr_r < base_r) ? base_r : lfsr_r; // [R17] [R18]

	// Lock base and victim pointer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			base_r <= '0;
			victim_r <= '0;
		end else if (tlb_we) begin
			victim_r <= victim_nxt; // [R19]
		end else if (wb_wr && wb_adr_i == REG_LOCK) begin
			base_r <= wb_dat_i[DMTW_IDX_W-1:0];
			victim_r <= (wb_dat_i[LOCK_VICT_LSB +: DMTW_IDX_W] <
				wb_dat_i[DMTW_IDX_W-1:0]) ? wb_dat_i[DMTW_IDX_W-1:0] :
				wb_dat_i[LOCK_VICT_LSB +: DMTW_IDX_W]; // [R18]
		end
	end

	// ****************************************
	// Translation sequencer
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= S_IDLE;
			va_r <= '0;
			wr_r <= 1'b0;
			mem_addr_r <= '0;
			fill_tag_r <= '0;
			fill_sz_r <= SZ_SECT;
			fill_ap_r <= '0;
			fill_ptag_r <= '0;
			rsp_valid_r <= 1'b0;
			rsp_paddr_r <= '0;
			rsp_fault_r <= FLT_NONE;
		end else begin
			rsp_valid_r <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (req_valid_i && !rsp_valid_r) begin
						va_r <= req_vaddr_i;
						wr_r <= req_write_i;
						if (ctrl_en) begin
							state_r <= S_SRCH;
						end else begin
							rsp_valid_r <= 1'b1;
							rsp_paddr_r <= 32'(req_vaddr_i);
							rsp_fault_r <= FLT_NONE;
						end
					end
				end
				S_SRCH: begin
					if (hit_any) begin
						state_r <= S_HIT; // [R16]
					end else if (walk_en) begin
						mem_addr_r <= {ttb_r[PA_MSB:TTB_KEEP_LSB], // [R5] [R6]
							va_r[VA_MSB:VA_SECT_LSB], 2'b00};
						state_r <= S_L1;
					end else begin
						rsp_valid_r <= 1'b1;
						rsp_fault_r <= FLT_MISS;
						state_r <= S_IDLE;
					end
				end
				S_HIT: begin
					rsp_valid_r <= 1'b1;
					state_r <= S_IDLE;
					rsp_paddr_r <= ({ram_q[DMTW_PTAG_W-1:0], 10'h000} & // [R26]
						~dmtw_off_mask(cam_sz_r[hit_idx])) |
						(32'(va_r) & dmtw_off_mask(cam_sz_r[hit_idx]));
					if (!hit_ap[1] || (wr_r && hit_ap == AP_RO)) begin // [R1]
						rsp_fault_r <= FLT_PERM; // [R25]
					end else begin
						rsp_fault_r <= FLT_NONE;
					end
				end
				S_L1: begin
					if (mem_ack_i) begin
						fill_tag_r <= va_r[VA_MSB:VA_TAG_LSB];
						fill_ptag_r <= walk_desc[PA_MSB:VA_TAG_LSB];
						fill_ap_r <= walk_desc[DESC_AP1_LSB +: 2];
						fill_sz_r <= SZ_SECT;
						case (walk_desc[1:0])
							L1_SECT: state_r <= S_FILL; // [R3] [R4]
							L1_COARSE: begin
								mem_addr_r <= {walk_desc[PA_MSB:VA_TAG_LSB], // [R2] [R13]
									va_r[VA_SECT_LSB-1:VA_CRS_LSB], 2'b00}; // [R7] [R8]
								state_r <= S_L2;
							end
							L1_FINE: begin
								mem_addr_r <= {walk_desc[PA_MSB:FINE_BASE_LSB], // [R14]
									va_r[VA_SECT_LSB-1:VA_TAG_LSB], 2'b00}; // [R7] [R9]
								state_r <= S_L2;
							end
							default: begin
								rsp_valid_r <= 1'b1; // [R2]
								rsp_fault_r <= FLT_XLAT;
								state_r <= S_IDLE;
							end
						endcase
					end
				end
				S_L2: begin
					if (mem_ack_i) begin
						fill_ptag_r <= walk_desc[PA_MSB:VA_TAG_LSB];
						fill_ap_r <= walk_desc[DESC_AP2_LSB +: 2]; // [R15]
						state_r <= S_FILL;
						case (walk_desc[1:0])
							L2_LARGE: fill_sz_r <= SZ_LARGE; // [R10] [R11] [R12]
							L2_SMALL: fill_sz_r <= SZ_SMALL;
							L2_TINY: fill_sz_r <= SZ_TINY;
							default: begin
								rsp_valid_r <= 1'b1; // [R15]
								rsp_fault_r <= FLT_XLAT;
								state_r <= S_IDLE;
							end
						endcase
					end
				end
				S_FILL: state_r <= S_SRCH;
				default: state_r <= S_IDLE;
			endcase
		end
	end

	assign req_stall_o = req_valid_i && !rsp_valid_r; // [R27]
	assign rsp_valid_o = rsp_valid_r;
	assign rsp_paddr_o = rsp_paddr_r;
	assign rsp_fault_o = rsp_fault_r;
	assign mem_req_o = (state_r == S_L1) || (state_r == S_L2);
	assign mem_addr_o = mem_addr_r;

	// ****************************************
	// Register bus slave
	// ****************************************
	assign wb_go = wb_cyc_i && wb_stb_i && !wb_ack_o && (state_r != S_FILL);
	assign wb_wr = wb_go && wb_we_i;
	assign cmd_go = wb_wr && (wb_adr_i == REG_CMD);

	// Acknowledge and read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_go;
			if (wb_go && !wb_we_i) begin
				wb_dat_o <= rd_mux;
			end
		end
	end

	// Read selection
	always_comb begin
		if (wb_adr_i == REG_CTRL) begin
			rd_mux = ctrl_r;
		end else if (wb_adr_i == REG_TTB) begin
			rd_mux = ttb_r;
		end else if (wb_adr_i == REG_LOCK) begin
			rd_mux = 32'({victim_r, 3'b000, base_r});
		end else if (wb_adr_i == REG_CAM) begin
			rd_mux = cam_reg_r;
		end else if (wb_adr_i == REG_RAM) begin
			rd_mux = ram_reg_r;
		end else if (wb_adr_i == REG_STAT) begin
			rd_mux = 32'({state_r != S_IDLE, fcode_r});
		end else if (wb_adr_i == REG_FADDR) begin
			rd_mux = faddr_r;
		end else if (wb_adr_i == REG_RDCAM) begin
			rd_mux = 32'({cam_valid_r[victim_r], cam_pres_r[victim_r],
				cam_sz_r[victim_r], cam_tag_r[victim_r]});
		end else if (wb_adr_i == REG_RDRAM) begin
			rd_mux = 32'(ram_q);
		end else begin
			rd_mux = '0;
		end
	end

	// Writable configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= '0;
			ttb_r <= '0;
			cam_reg_r <= '0;
			ram_reg_r <= '0;
		end else if (wb_wr) begin
			if (wb_adr_i == REG_CTRL) begin
				ctrl_r <= dmtw_merge(ctrl_r, wb_dat_i, wb_sel_i) & 32'h0000_0003;
			end else if (wb_adr_i == REG_TTB) begin
				ttb_r <= dmtw_merge(ttb_r, wb_dat_i, wb_sel_i) & TTB_MASK;
			end else if (wb_adr_i == REG_CAM) begin
				cam_reg_r <= dmtw_merge(cam_reg_r, wb_dat_i, wb_sel_i) &
					32'h0003_FFFF;
			end else if (wb_adr_i == REG_RAM) begin
				ram_reg_r <= dmtw_merge(ram_reg_r, wb_dat_i, wb_sel_i) &
					32'h00FF_FFFF;
			end
		end
	end

	// Fault record; a new fault wins over a clearing write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fcode_r <= FLT_NONE;
			faddr_r <= '0;
		end else if (rsp_valid_r && rsp_fault_r != FLT_NONE) begin
			fcode_r <= rsp_fault_r;
			faddr_r <= 32'(va_r);
		end else if (wb_wr && wb_adr_i == REG_STAT) begin
			fcode_r <= FLT_NONE;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_stall_held: assert property (req_valid_i && state_r != S_IDLE |-> req_stall_o) else $error("request not stalled in walk"); // [R27]
	a_l1_address: assert property (state_r == S_SRCH && !hit_any && walk_en |=> mem_req_o && mem_addr_o == {ttb_r[31:6], va_r[23:20], 2'b00}) else $error("bad level one address"); // [R5]
	a_sect_fill: assert property (state_r == S_L1 && mem_ack_i && mem_rdata_i[1:0] == L1_SECT |=> state_r == S_FILL && fill_sz_r == SZ_SECT) else $error("section not filled"); // [R3]
	a_coarse_index: assert property (state_r == S_L1 && mem_ack_i && mem_rdata_i[1:0] == L1_COARSE |=> mem_addr_o[9:2] == va_r[19:12] && state_r == S_L2) else $error("bad coarse index"); // [R7]
	a_large_fill: assert property (state_r == S_L2 && mem_ack_i && mem_rdata_i[1:0] == L2_LARGE |=> fill_sz_r == SZ_LARGE && fill_ap_r == $past(mem_rdata_i[5:4])) else $error("bad large page fill"); // [R15]
	a_fill_hits: assert property (state_r == S_FILL |=> state_r == S_SRCH ##1 state_r == S_HIT ##1 rsp_valid_o) else $error("fill did not hit"); // [R16]
	a_perm_write: assert property (state_r == S_HIT && wr_r && hit_ap == AP_RO |=> rsp_valid_o && rsp_fault_o == FLT_PERM) else $error("write to read-only passed"); // [R25]
	a_miss_nowalk: assert property (state_r == S_SRCH && !hit_any && !walk_en |=> rsp_valid_o && rsp_fault_o == FLT_MISS) else $error("miss not reported"); // [R20]
	a_victim_lock: assert property (victim_r >= base_r) else $error("victim inside locked region"); // [R18]
	a_gflush_keep: assert property (cmd_go && wb_dat_i[CMD_GFLUSH_BIT] && !wb_dat_i[CMD_LOAD_BIT] |=> (cam_valid_r & ~$past(cam_pres_r)) == '0) else $error("flush kept unpreserved"); // [R24]
	a_invalid_miss: assert property ((hit_vec & ~cam_valid_r) == '0) else $error("invalid entry matched"); // [R23]

	c_walk_sect: cover property (state_r == S_L1 && mem_ack_i && mem_rdata_i[1:0] == L1_SECT);
	c_walk_two: cover property (state_r == S_L2 ##1 state_r == S_FILL);
	c_perm_fault: cover property (rsp_valid_o && rsp_fault_o == FLT_PERM);
	c_hit_direct: cover property (state_r == S_IDLE ##1 state_r == S_SRCH ##1 state_r == S_HIT);

endmodule

/* File: pkg/dmtw_pkg.sv */
package dmtw_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int DMTW_ENTRIES = 32;
	localparam int DMTW_IDX_W = 5;
	localparam int DMTW_VTAG_W = 14;
	localparam int DMTW_PTAG_W = 22;
	localparam int DMTW_RAM_W = 24;

	// ****************************************
	// Address field positions
	// ****************************************
	localparam int VA_MSB = 23;
	localparam int VA_SECT_LSB = 20;
	localparam int VA_CRS_LSB = 12;
	localparam int VA_TAG_LSB = 10;
	localparam int PA_MSB = 31;
	localparam int TTB_KEEP_LSB = 6;
	localparam int TTB_ALIGN_LSB = 7;
	localparam int FINE_BASE_LSB = 12;
	localparam int DESC_AP1_LSB = 10;
	localparam int DESC_AP2_LSB = 4;
	localparam int RAM_AP_LSB = 22;

	// ****************************************
	// Register map and fields
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TTB = 8'h04;
	localparam logic [7:0] REG_LOCK = 8'h08;
	localparam logic [7:0] REG_CAM = 8'h0C;
	localparam logic [7:0] REG_RAM = 8'h10;
	localparam logic [7:0] REG_CMD = 8'h14;
	localparam logic [7:0] REG_STAT = 8'h18;
	localparam logic [7:0] REG_FADDR = 8'h1C;
	localparam logic [7:0] REG_RDCAM = 8'h20;
	localparam logic [7:0] REG_RDRAM = 8'h24;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_WALK_BIT = 1;
	localparam int CMD_LOAD_BIT = 0;
	localparam int CMD_GFLUSH_BIT = 1;
	localparam int CMD_FLENT_BIT = 2;
	localparam int LOCK_VICT_LSB = 8;
	localparam int CAM_SZ_LSB = 14;
	localparam int CAM_PRES_BIT = 16;
	localparam int CAM_VALID_BIT = 17;
	localparam int STAT_BUSY_BIT = 2;
	localparam logic [31:0] TTB_MASK = 32'hFFFF_FF80;

	// ****************************************
	// Encodings
	// ****************************************
	typedef enum logic [1:0] {
		SZ_SECT = 2'b00, SZ_LARGE = 2'b01, SZ_SMALL = 2'b10, SZ_TINY = 2'b11
	} dmtw_size_t;
	localparam logic [1:0] DESC_FAULT = 2'b00;
	localparam logic [1:0] L1_COARSE = 2'b01;
	localparam logic [1:0] L1_SECT = 2'b10;
	localparam logic [1:0] L1_FINE = 2'b11;
	localparam logic [1:0] L2_LARGE = 2'b01;
	localparam logic [1:0] L2_SMALL = 2'b10;
	localparam logic [1:0] L2_TINY = 2'b11;
	localparam logic [1:0] AP_RO = 2'b10;
	typedef enum logic [1:0] {
		FLT_NONE = 2'b00, FLT_MISS = 2'b01, FLT_XLAT = 2'b10, FLT_PERM = 2'b11
	} dmtw_fault_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_SRCH = 3'b001, S_HIT = 3'b010,
		S_L1 = 3'b011, S_L2 = 3'b100, S_FILL = 3'b101
	} dmtw_state_t;
	localparam logic [4:0] LFSR_SEED = 5'h1F;

	// Virtual tag bits significant for an entry size
	function automatic logic [13:0] dmtw_tag_mask(input logic [1:0] sz);
		case (sz)
			SZ_SECT: dmtw_tag_mask = 14'h3C00;
			SZ_LARGE: dmtw_tag_mask = 14'h3FC0;
			SZ_SMALL: dmtw_tag_mask = 14'h3FFC;
			default: dmtw_tag_mask = 14'h3FFF;
		endcase
	endfunction

	// Untranslated offset bits for an entry size
	function automatic logic [31:0] dmtw_off_mask(input logic [1:0] sz);
		case (sz)
			SZ_SECT: dmtw_off_mask = 32'h000F_FFFF;
			SZ_LARGE: dmtw_off_mask = 32'h0000_FFFF;
			SZ_SMALL: dmtw_off_mask = 32'h0000_0FFF;
			default: dmtw_off_mask = 32'h0000_03FF;
		endcase
	endfunction

	// Byte-lane merge of a bus write
	function automatic logic [31:0] dmtw_merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] sel);
		for (int b = 0; b < 4; b++) begin
			old[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		end
		dmtw_merge = old;
	endfunction

endpackage

/* File: logic/dmtw_tlb_ram.sv */
`timescale 1ns/1ps
module dmtw_tlb_ram
	import dmtw_pkg::*;
(
	input wire logic clk_i, // System clock
	input wire logic we_i, // Write strobe
	input wire logic [DMTW_IDX_W-1:0] waddr_i, // Write entry
	input wire logic [DMTW_RAM_W-1:0] wdata_i, // Permission and page base
	input wire logic [DMTW_IDX_W-1:0] raddr_i, // Read entry
	output logic [DMTW_RAM_W-1:0] rdata_o // Registered read data
);

	logic [DMTW_RAM_W-1:0] mem_r [DMTW_ENTRIES];

	// Write port
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_r[waddr_i] <= wdata_i;
		end
	end

	// Registered read port
	always_ff @(posedge clk_i) begin
		rdata_o <= mem_r[raddr_i];
	end

endmodule

/* File: bench/dmtw_mem_model.sv */
`timescale 1ns/1ps
module dmtw_mem_model (
	input wire logic clk_i, // System clock
	input wire logic req_i, // Descriptor fetch
	input wire logic [31:0] addr_i, // Descriptor address
	output logic ack_o, // Word ready
	output logic [31:0] rdata_o // Descriptor word
);
	logic [31:0] mem [logic [31:0]];
	int lat = 0;
	int cnt = 0;
	int fetches = 0;
	initial begin
		ack_o = 1'b0;
		rdata_o = 32'h0000_0000;
	end
	// Answer a held fetch after lat cycles; data toggles when not valid
	always @(posedge clk_i) begin
		if (ack_o || !req_i) begin
			ack_o <= 1'b0;
			rdata_o <= ~rdata_o;
			cnt <= 0;
		end else if (cnt >= lat) begin
			ack_o <= 1'b1;
			rdata_o <= mem.exists(addr_i) ? mem[addr_i] : 32'h0000_0000;
			fetches <= fetches + 1;
		end else begin
			cnt <= cnt + 1;
			rdata_o <= ~rdata_o;
		end
	end
endmodule

/* File: bench/tb_dsp_mmu_table_walk_tlb.sv */
`timescale 1ns/1ps
module tb_dsp_mmu_table_walk_tlb;
	import dmtw_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, rv, rw, ack, stall, rsv, mreq, mack;
	logic [7:0] adr;
	logic [1:0] flt, xf;
	logic [23:0] va;
	logic [31:0] wdat, rdat, rdv, pa, xpa, ma, md;
	int bad_count = 0;
	int cmp_count = 0;
	int f0;

	dmtw_mmu dmtw_mmu_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .req_valid_i(rv),
		.req_vaddr_i(va), .req_write_i(rw), .req_stall_o(stall),
		.rsp_valid_o(rsv), .rsp_paddr_o(pa), .rsp_fault_o(flt),
		.mem_req_o(mreq), .mem_addr_o(ma), .mem_ack_i(mack),
		.mem_rdata_i(md));
	dmtw_mem_model dmtw_mem_model_i (.clk_i(clk_i), .req_i(mreq),
		.addr_i(ma), .ack_o(mack), .rdata_o(md));

	// ****************************************
	// Clock, watchdog and verdict
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		#(25 * 20000);
		bad_count++;
		end_sim();
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ****************************************
	// Bus, translation and compare tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) bad_count++;
		rdv = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic tr(input logic [23:0] v, input logic w,
			input logic [31:0] ep, input logic [1:0] ef);
		int n = 0;
		int ns = 0;
		logic st;
		@(posedge clk_i);
		rv <= 1'b1;
		va <= v;
		rw <= w;
		do begin
			@(posedge clk_i);
			n++;
			if (rsv !== 1'b1 && stall !== 1'b1) ns++;
		end while (rsv !== 1'b1 && n < 300);
		if (n >= 300) bad_count++;
		xpa = pa;
		xf = flt;
		st = stall;
		rv <= 1'b0;
		chk(32'(ns), 32'h0000_0000);
		chk({31'h0, st}, 32'h0000_0000);
		chk({30'h0, xf}, {30'h0, ef});
		if (ef == FLT_NONE) chk(xpa, ep);
	endtask
	task automatic nf(input int exp);
		chk(32'(dmtw_mem_model_i.fetches - f0), 32'(exp));
		f0 = dmtw_mem_model_i.fetches;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_setup;
		tr(24'hAB_CDEF, 1'b0, 32'h00AB_CDEF, FLT_NONE);
		wb(1'b1, REG_TTB, 32'h0001_00FF);
		wb(1'b0, REG_TTB, 32'h0);
		chk(rdv, 32'h0001_0080);
		wb(1'b0, 8'h40, 32'h0);
		chk(rdv, 32'h0);
		wb(1'b1, REG_TTB, 32'h0001_0000);
		wb(1'b1, REG_CTRL, 32'h0000_0003);
		$display("setup done");
	endtask
	task automatic t_sect;
		f0 = dmtw_mem_model_i.fetches;
		tr(24'h31_2345, 1'b0, 32'h8761_2345, FLT_NONE);
		nf(1);
		tr(24'h35_4321, 1'b1, 32'h8765_4321, FLT_NONE);
		nf(0);
		$display("section done");
	endtask
	task automatic t_coarse;
		dmtw_mem_model_i.lat = 3;
		tr(24'h52_3456, 1'b0, 32'h4321_3456, FLT_NONE);
		nf(2);
		tr(24'h52_0ABC, 1'b1, 32'h4321_0ABC, FLT_NONE);
		nf(0);
		tr(24'h54_0ABC, 1'b0, 32'h5555_6ABC, FLT_NONE);
		tr(24'h6A_BC12, 1'b0, 32'hCAFE_0412, FLT_NONE);
		nf(4);
		dmtw_mem_model_i.lat = 0;
		$display("two-level done");
	endtask
	task automatic t_fault;
		tr(24'h70_0000, 1'b0, 32'h0, FLT_XLAT);
		tr(24'h80_0010, 1'b1, 32'h0, FLT_PERM);
		tr(24'h80_0010, 1'b0, 32'h9000_0010, FLT_NONE);
		tr(24'h90_0000, 1'b0, 32'h0, FLT_PERM);
		wb(1'b0, REG_FADDR, 32'h0);
		chk(rdv, 32'h0090_0000);
		wb(1'b0, REG_STAT, 32'h0);
		chk(rdv, 32'h0000_0003);
		$display("faults done");
	endtask
	task automatic t_flush;
		wb(1'b1, REG_LOCK, 32'h0);
		wb(1'b1, REG_CAM, 32'h0003_2800);
		wb(1'b1, REG_RAM, 32'h00EC_0000);
		wb(1'b1, REG_CMD, 32'h0000_0001);
		wb(1'b1, REG_LOCK, 32'h0000_0101);
		wb(1'b1, REG_CMD, 32'h0000_0002);
		f0 = dmtw_mem_model_i.fetches;
		tr(24'hA1_2345, 1'b0, 32'hB001_2345, FLT_NONE);
		nf(0);
		tr(24'h31_2345, 1'b0, 32'h8761_2345, FLT_NONE);
		nf(1);
		wb(1'b1, REG_CMD, 32'h0000_0004);
		tr(24'hA1_2345, 1'b0, 32'h0, FLT_XLAT);
		nf(1);
		wb(1'b1, REG_CTRL, 32'h0000_0001);
		tr(24'h7F_0000, 1'b0, 32'h0, FLT_MISS);
		nf(0);
		$display("flush done");
	endtask

	// ****************************************
	// Tables, reset and main sequence
	// ****************************************
	initial begin
		dmtw_mem_model_i.mem[32'h0001_000C] = 32'h8760_0C02;
		dmtw_mem_model_i.mem[32'h0001_0014] = 32'h0002_0001;
		for (int i = 32; i < 48; i++) begin
			dmtw_mem_model_i.mem[32'h0002_0000 + 4 * i] = 32'h4321_0031;
		end
		dmtw_mem_model_i.mem[32'h0002_0100] = 32'h5555_6032;
		dmtw_mem_model_i.mem[32'h0001_0018] = 32'h0003_0003;
		dmtw_mem_model_i.mem[32'h0003_0ABC] = 32'hCAFE_0433;
		dmtw_mem_model_i.mem[32'h0001_0020] = 32'h9000_0802;
		dmtw_mem_model_i.mem[32'h0001_0024] = 32'hA000_0002;
		rst_i = 1'b1;
		{cyc, stb, we, rv, rw} = 5'h0;
		adr = 8'h00;
		wdat = 32'h0;
		va = 24'h0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_setup();
		t_sect();
		t_coarse();
		t_fault();
		t_flush();
		end_sim();
	end
endmodule
